// ==== cko_regs.vh ====
`ifndef CKO_REGS_VH
`define CKO_REGS_VH

// Register bus geometry.
`define CKO_ADDR_W          15
`define CKO_DATA_W          8

// Register offsets.
`define CKO_OFS_PREEMPH     15'h0048
`define CKO_OFS_TRIG_CTRL   15'h0057
`define CKO_OFS_SYNTH_OVR   15'h0058

// Reset values.
`define CKO_RST_PREEMPH     8'h00
`define CKO_RST_TRIG_CTRL   8'h00
`define CKO_RST_SYNTH_OVR   8'h00
`define CKO_RD_UNMAPPED     8'h00

// Pre-emphasis field and lane count.
`define CKO_PE_MSB          3
`define CKO_PE_LSB          0
`define CKO_PE_W            4
`define CKO_NUM_LANES       8

// Trigger output control fields.
`define CKO_TRIG_EN_BIT     7
`define CKO_TRIG_SEL_MSB    2
`define CKO_TRIG_SEL_LSB    0
`define CKO_TRIG_SEL_UI16   3'h0
`define CKO_TRIG_SEL_UI32   3'h1
`define CKO_TRIG_SEL_UI64   3'h2
`define CKO_TRIG_SEL_TSTAMP 3'h3

// Half-period of each trigger clock in 8 UI serializer ticks, minus one.
`define CKO_TRIG_HALF_UI16  2'h0
`define CKO_TRIG_HALF_UI32  2'h1
`define CKO_TRIG_HALF_UI64  2'h3

// Synthesizer override fields.
`define CKO_OVR_EN_BIT      7
`define CKO_OVR_SECOND_MSB  5
`define CKO_OVR_SECOND_LSB  4
`define CKO_OVR_FIRST_MSB   3
`define CKO_OVR_FIRST_LSB   2
`define CKO_OVR_SE_REF_BIT  1
`define CKO_OVR_SYN_EN_BIT  0

// Divided reference output codes.
`define CKO_DIV_OFF         2'h0
`define CKO_DIV_BY1         2'h1
`define CKO_DIV_BY2         2'h2
`define CKO_DIV_BY4         2'h3

// Half-period of each divided reference output in reference ticks, minus one.
`define CKO_REFDIV_HALF_BY1 2'h0
`define CKO_REFDIV_HALF_BY2 2'h1
`define CKO_REFDIV_HALF_BY4 2'h3

`endif

// ==== cko_refdiv.v ====
`timescale 1ns/100ps
`default_nettype none
`include "cko_regs.vh"

module cko_refdiv (
   // Clock and reset
   input  wire       clk,
   input  wire       arst_n,
   input  wire       ce,
   // Control
   input  wire       enable,
   input  wire [1:0] mode,
   input  wire       ref_tick,
   // Output
   output reg        div_out
);

   reg  [1:0] cnt_reg;
   reg  [1:0] half_lim;

   // Divide by 1 toggles each reference half-cycle tick, by 2 every second, by 4 every fourth.
   always @* begin
      case (mode)
         `CKO_DIV_BY1: half_lim = `CKO_REFDIV_HALF_BY1;
         `CKO_DIV_BY2: half_lim = `CKO_REFDIV_HALF_BY2;
         `CKO_DIV_BY4: half_lim = `CKO_REFDIV_HALF_BY4;
         default:      half_lim = `CKO_REFDIV_HALF_BY1;
      endcase
   end

   // A disabled output parks low so that a later enable starts on a clean edge.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 2'h0;
         div_out <= 1'b0;
      end else if (ce) begin
         if (!enable || mode == `CKO_DIV_OFF) begin
            cnt_reg <= 2'h0;
            div_out <= 1'b0;
         end else if (ref_tick) begin
            if (cnt_reg >= half_lim) begin
               cnt_reg <= 2'h0;
               div_out <= ~div_out;
            end else begin
               cnt_reg <= cnt_reg + 2'h1;
            end
         end
      end
   end

endmodule // cko_refdiv
`default_nettype wire

// ==== cko_top.v ====
// Notes on behaviour
// RULE1: The four-bit pre-emphasis value in bits 3:0 is driven identically to every serial output lane.
// RULE2: The host writes zero to reserved bits, including bits 7:4 of the pre-emphasis register.
// RULE3: Bit 7 of the trigger control register enables the trigger output buffer and divider when set.
// RULE4: Trigger select code 0, 1, 2 gives a 16, 32, 64 UI clock, code 3 the resampled timestamp, 4 to 7 reserved.
// RULE5: The host changes the trigger select field only while the trigger enable bit is zero.
// RULE6: Trigger clocks for codes 2 and below come from the serializer and stop while it is reinitialized.
// RULE7: Override bit 7 chooses register fields over the configuration pins to control the synthesizer.
// RULE8: Under override, field 5:4 selects off or reference divided by 1, 2, 4 on the second divided output.
// RULE9: The second divided reference output runs only while the first one is running.
// RULE10: Under override, field 3:2 selects off or reference divided by 1, 2, 4 on the first divided output.
// RULE11: Under override, bit 1 replaces the reference-select pin and picks the single-ended reference.
// RULE12: Under override, bit 0 replaces the synthesizer enable pin.
// RULE13: A reserved trigger select code keeps the trigger output static low.
`timescale 1ns/100ps
`default_nettype none
`include "cko_regs.vh"

module cko_top (
   // Clock, reset and clock enable
   input  wire                                    clk,
   input  wire                                    arst_n,
   input  wire                                    ce,
   // Register access from the serial control port
   input  wire [`CKO_ADDR_W-1:0]                  reg_addr,
   input  wire [`CKO_DATA_W-1:0]                  reg_wdata,
   input  wire                                    reg_wr,
   input  wire                                    reg_rd,
   output reg  [`CKO_DATA_W-1:0]                  reg_rdata,
   // Serializer side
   output wire [`CKO_NUM_LANES*`CKO_PE_W-1:0]     lane_preemphasis_level,
   input  wire                                    ser_ui8_tick,
   input  wire                                    ser_reinit,
   // Trigger output
   input  wire                                    timestamp_input,
   output reg                                     trigger_output,
   output wire                                    trigger_output_enable,
   // Synthesizer pins and controls
   input  wire                                    synth_enable_pin,
   input  wire                                    ref_select_pin,
   input  wire                                    clock_config_pin_a,
   input  wire                                    clock_config_pin_b,
   input  wire                                    synth_ref_tick,
   output reg                                     synth_enable,
   output reg                                     single_ended_ref_select,
   output wire                                    first_divided_ref_out,
   output wire                                    second_divided_ref_out
);

   reg  [`CKO_DATA_W-1:0] preemph_reg;
   reg  [`CKO_DATA_W-1:0] trig_ctrl_reg;
   reg  [`CKO_DATA_W-1:0] synth_ovr_reg;
   reg  [`CKO_DATA_W-1:0] rdata_next;
   reg  [1:0]             trig_cnt_reg;
   reg                    trig_clk_reg;
   reg  [1:0]             trig_half;
   reg                    trig_is_clk;
   reg  [1:0]             first_sel;
   reg  [1:0]             second_sel;
   reg                    first_running;

   wire                   ovr_en;
   wire [2:0]             trigger_output_select;

   //////////////////////////////////////////////////////////////////////////////
   // Register file

   // Reserved bits are stored as written; the host is expected to keep them zero.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         preemph_reg   <= `CKO_RST_PREEMPH;
         trig_ctrl_reg <= `CKO_RST_TRIG_CTRL;
         synth_ovr_reg <= `CKO_RST_SYNTH_OVR;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            `CKO_OFS_PREEMPH:   preemph_reg   <= reg_wdata;
            `CKO_OFS_TRIG_CTRL: trig_ctrl_reg <= reg_wdata;
            `CKO_OFS_SYNTH_OVR: synth_ovr_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   always @* begin
      case (reg_addr)
         `CKO_OFS_PREEMPH:   rdata_next = preemph_reg;
         `CKO_OFS_TRIG_CTRL: rdata_next = trig_ctrl_reg;
         `CKO_OFS_SYNTH_OVR: rdata_next = synth_ovr_reg;
         default:            rdata_next = `CKO_RD_UNMAPPED;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= `CKO_RD_UNMAPPED;
      end else if (ce && reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Lane pre-emphasis

   genvar lane;
   generate
      for (lane = 0; lane < `CKO_NUM_LANES; lane = lane + 1) begin : g_lane
         assign lane_preemphasis_level[lane*`CKO_PE_W +: `CKO_PE_W] =
                preemph_reg[`CKO_PE_MSB:`CKO_PE_LSB]; // RULE1
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // Trigger output

   assign trigger_output_enable = trig_ctrl_reg[`CKO_TRIG_EN_BIT]; // RULE3
   assign trigger_output_select = trig_ctrl_reg[`CKO_TRIG_SEL_MSB:`CKO_TRIG_SEL_LSB];

   always @* begin
      trig_is_clk = 1'b1;
      case (trigger_output_select) // RULE4
         `CKO_TRIG_SEL_UI16: trig_half = `CKO_TRIG_HALF_UI16;
         `CKO_TRIG_SEL_UI32: trig_half = `CKO_TRIG_HALF_UI32;
         `CKO_TRIG_SEL_UI64: trig_half = `CKO_TRIG_HALF_UI64;
         default: begin
            trig_half   = `CKO_TRIG_HALF_UI16;
            trig_is_clk = 1'b0;
         end
      endcase
   end

   // The divider runs on serializer ticks, so a reinitialization drops the clock
   // and restarts it in phase once the serializer is back.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_cnt_reg <= 2'h0;
         trig_clk_reg <= 1'b0;
      end else if (ce) begin
         if (!trigger_output_enable || !trig_is_clk || ser_reinit) begin // RULE6
            trig_cnt_reg <= 2'h0;
            trig_clk_reg <= 1'b0;
         end else if (ser_ui8_tick) begin
            if (trig_cnt_reg >= trig_half) begin
               trig_cnt_reg <= 2'h0;
               trig_clk_reg <= ~trig_clk_reg;
            end else begin
               trig_cnt_reg <= trig_cnt_reg + 2'h1;
            end
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trigger_output <= 1'b0;
      end else if (ce) begin
         if (!trigger_output_enable) begin
            trigger_output <= 1'b0; // RULE3
         end else if (trig_is_clk) begin
            trigger_output <= trig_clk_reg;
         end else if (trigger_output_select == `CKO_TRIG_SEL_TSTAMP) begin
            trigger_output <= timestamp_input; // RULE4
         end else begin
            trigger_output <= 1'b0; // RULE13
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Synthesizer control source and divided reference outputs

   assign ovr_en = synth_ovr_reg[`CKO_OVR_EN_BIT];

   // In pin mode both configuration pins form the first output's code and the
   // second output stays off, since pins offer no separate code for it.
   always @* begin
      if (ovr_en) begin // RULE7
         first_sel  = synth_ovr_reg[`CKO_OVR_FIRST_MSB:`CKO_OVR_FIRST_LSB]; // RULE10
         second_sel = synth_ovr_reg[`CKO_OVR_SECOND_MSB:`CKO_OVR_SECOND_LSB]; // RULE8
      end else begin
         first_sel  = {clock_config_pin_b, clock_config_pin_a}; // RULE10
         second_sel = `CKO_DIV_OFF; // RULE8
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         synth_enable            <= 1'b0;
         single_ended_ref_select <= 1'b0;
      end else if (ce) begin
         synth_enable            <= ovr_en ? synth_ovr_reg[`CKO_OVR_SYN_EN_BIT] : synth_enable_pin; // RULE12
         single_ended_ref_select <= ovr_en ? synth_ovr_reg[`CKO_OVR_SE_REF_BIT] : ref_select_pin; // RULE11
      end
   end

   // Gating the second output on the first keeps it from running alone.
   always @* begin
      first_running = synth_enable && (first_sel != `CKO_DIV_OFF); // RULE9
   end

   cko_refdiv u_first_div (
      .clk      (clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .enable   (synth_enable),
      .mode     (first_sel),
      .ref_tick (synth_ref_tick),
      .div_out  (first_divided_ref_out)
   );

   cko_refdiv u_second_div (
      .clk      (clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .enable   (first_running), // RULE9
      .mode     (second_sel),
      .ref_tick (synth_ref_tick),
      .div_out  (second_divided_ref_out)
   );

endmodule // cko_top
`default_nettype wire

// ==== cko_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cko_regs.vh"

module cko_host (
   // Clock and read data
   input  wire logic                   clk,
   input  wire logic [`CKO_DATA_W-1:0] reg_rdata,
   // Register strobes
   output var  logic [`CKO_ADDR_W-1:0] reg_addr,
   output var  logic [`CKO_DATA_W-1:0] reg_wdata,
   output var  logic                   reg_wr,
   output var  logic                   reg_rd
);
   initial begin
      reg_addr = 15'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   ////////////////////////////////////////
   task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d & (a == `CKO_OFS_PREEMPH ? 8'h0F : a == `CKO_OFS_TRIG_CTRL ? 8'h87 : 8'hBF);
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      q = reg_rdata;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // Released lines carry junk so that a late sample cannot match by luck.
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule // cko_host
`default_nettype wire

// ==== cko_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cko_regs.vh"

module cko_chk (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  arst_n,
   input wire logic                  ce,
   // Register writes
   input wire logic [14:0]           reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   // Serializer and trigger
   input wire logic [31:0]           lane_preemphasis_level,
   input wire logic                  ser_reinit,
   input wire logic                  timestamp_input,
   input wire logic                  trigger_output,
   input wire logic                  trigger_output_enable,
   // Synthesizer
   input wire logic                  synth_enable_pin,
   input wire logic                  ref_select_pin,
   input wire logic                  synth_enable,
   input wire logic                  single_ended_ref_select,
   input wire logic                  first_divided_ref_out,
   input wire logic                  second_divided_ref_out
);
   // Shadow copies let the checker know the mode without looking inside.
   logic [7:0] tc_reg;
   logic [7:0] ov_reg;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tc_reg <= 8'h00;
         ov_reg <= 8'h00;
      end else if (ce && reg_wr) begin
         if (reg_addr == `CKO_OFS_TRIG_CTRL) tc_reg <= reg_wdata;
         if (reg_addr == `CKO_OFS_SYNTH_OVR) ov_reg <= reg_wdata;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence reinit_s;
      ce && ser_reinit && tc_reg[2:0] <= 3'h2 ##1 ce;
   endsequence
   lane_share_a: assert property (ce && reg_wr && reg_addr == `CKO_OFS_PREEMPH |=>
      lane_preemphasis_level == {8{$past(reg_wdata[3:0])}}) else $error("lane level wrong");
   trig_en_a: assert property (ce && reg_wr && reg_addr == `CKO_OFS_TRIG_CTRL |=>
      trigger_output_enable == $past(reg_wdata[7])) else $error("trigger enable wrong");
   trig_off_a: assert property (ce && !tc_reg[7] |=> !trigger_output) else $error("disabled output moved");
   trig_stamp_a: assert property (ce && tc_reg[7] && tc_reg[2:0] == 3'h3 |=>
      trigger_output == $past(timestamp_input)) else $error("timestamp not followed");
   trig_reinit_a: assert property (reinit_s |=> !trigger_output) else $error("clock ran in reinit");
   trig_rsvd_a: assert property (ce && tc_reg[2:0] > 3'h3 |=> !trigger_output) else $error("reserved mode moved");
   ovr_value_a: assert property (ce && ov_reg[7] |=> synth_enable == $past(ov_reg[0]) &&
      single_ended_ref_select == $past(ov_reg[1])) else $error("override value wrong");
   pin_value_a: assert property (ce && !ov_reg[7] |=> synth_enable == $past(synth_enable_pin) &&
      single_ended_ref_select == $past(ref_select_pin)) else $error("pin value wrong");
   second_gate_a: assert property (ce && (!ov_reg[7] || ov_reg[3:2] == 2'h0) |=>
      !second_divided_ref_out) else $error("second output ran alone");
   first_off_a: assert property (ce && ov_reg[7] && ov_reg[3:2] == 2'h0 |=>
      !first_divided_ref_out) else $error("first output ran while off");
endmodule // cko_chk
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cko_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end

module tb;
   logic clk = 0, arst_n = 0, ce = 1, ser_ui8_tick = 0, ser_reinit = 0, timestamp_input = 0, synth_ref_tick = 0;
   logic synth_enable_pin = 0, ref_select_pin = 0, clock_config_pin_a = 0, clock_config_pin_b = 0;
   logic [14:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q;
   logic reg_wr, reg_rd, trigger_output, trigger_output_enable, synth_enable, single_ended_ref_select;
   logic first_divided_ref_out, second_divided_ref_out;
   logic [31:0] lane_preemphasis_level;
   int n_mismatch = 0, check_count = 0, cyc = 0, nt, nf, ns;
   cko_top i_cko_top (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .lane_preemphasis_level, .ser_ui8_tick, .ser_reinit, .timestamp_input, .trigger_output,
      .trigger_output_enable, .synth_enable_pin, .ref_select_pin, .clock_config_pin_a, .clock_config_pin_b,
      .synth_ref_tick, .synth_enable, .single_ended_ref_select, .first_divided_ref_out, .second_divided_ref_out);
   cko_host host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude;
      end
   end
   ////////////////////////////////////////
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   // Pulses both tick inputs n times, two cycles apart, and counts output edges.
   task automatic run(input int n);
      logic t, f, s;
      nt = 0; nf = 0; ns = 0;
      @(negedge clk);
      t = trigger_output; f = first_divided_ref_out; s = second_divided_ref_out;
      for (int i = 0; i < 2 * n + 4; i++) begin
         ser_ui8_tick = (i < 2 * n) && !i[0];
         synth_ref_tick = ser_ui8_tick;
         @(negedge clk);
         nt += (trigger_output !== t); nf += (first_divided_ref_out !== f); ns += (second_divided_ref_out !== s);
         t = trigger_output; f = first_divided_ref_out; s = second_divided_ref_out;
      end
   endtask
   task automatic t_regs;
      logic [14:0] a [4] = '{`CKO_OFS_PREEMPH, `CKO_OFS_TRIG_CTRL, `CKO_OFS_SYNTH_OVR, 15'h0049};
      foreach (a[i]) begin
         host.xfer(1'b0, a[i], 8'h00, q);
         `CHK(q, 8'h00)
      end
      wr(`CKO_OFS_PREEMPH, 8'h0A);
      wr(15'h0049, 8'h0F);
      `CHK(lane_preemphasis_level, {8{4'hA}})
      host.xfer(1'b0, `CKO_OFS_PREEMPH, 8'h00, q);
      `CHK(q, 8'h0A)
      host.xfer(1'b0, 15'h0049, 8'h00, q);
      `CHK(q, 8'h00)
      $display("done regs");
   endtask
   task automatic t_trig;
      for (int m = 0; m < 3; m++) begin
         wr(`CKO_OFS_TRIG_CTRL, 8'(m));
         wr(`CKO_OFS_TRIG_CTRL, 8'h80 | 8'(m));
         run(8);
         `CHK(nt, 8 >> m)
         `CHK(trigger_output_enable, 1'b1)
         wr(`CKO_OFS_TRIG_CTRL, 8'(m));
      end
      wr(`CKO_OFS_TRIG_CTRL, 8'h02);
      run(8);
      `CHK(nt, 0)
      wr(`CKO_OFS_TRIG_CTRL, 8'h05);
      wr(`CKO_OFS_TRIG_CTRL, 8'h85);
      run(8);
      `CHK(nt, 0)
      `CHK(trigger_output, 1'b0)
      wr(`CKO_OFS_TRIG_CTRL, 8'h05);
      $display("done trigger");
   endtask
   task automatic t_reinit_stamp;
      wr(`CKO_OFS_TRIG_CTRL, 8'h00);
      wr(`CKO_OFS_TRIG_CTRL, 8'h80);
      ser_reinit = 1'b1;
      repeat (3) @(negedge clk);
      run(8);
      `CHK(nt, 0)
      `CHK(trigger_output, 1'b0)
      ser_reinit = 1'b0;
      run(4);
      `CHK(nt, 4)
      wr(`CKO_OFS_TRIG_CTRL, 8'h00);
      wr(`CKO_OFS_TRIG_CTRL, 8'h03);
      wr(`CKO_OFS_TRIG_CTRL, 8'h83);
      for (int i = 0; i < 4; i++) begin
         timestamp_input = ~timestamp_input;
         @(negedge clk);
         `CHK(trigger_output, timestamp_input)
      end
      $display("done reinit and stamp");
   endtask
   task automatic t_synth;
      synth_enable_pin = 1'b1;
      ref_select_pin = 1'b1;
      clock_config_pin_b = 1'b1;
      run(8);
      `CHK(synth_enable, 1'b1)
      `CHK(single_ended_ref_select, 1'b1)
      `CHK(nf, 4)
      `CHK(ns, 0)
      synth_enable_pin = 1'b0;
      ref_select_pin = 1'b0;
      for (logic [1:0] c = 2'h1; c != 2'h0; c++) begin
         wr(`CKO_OFS_SYNTH_OVR, {2'b10, c, c, c[0], 1'b1});
         run(8);
         `CHK(nf, 8 >> (c - 1))
         `CHK(ns, 8 >> (c - 1))
         `CHK(synth_enable, 1'b1)
         `CHK(single_ended_ref_select, c[0])
      end
      wr(`CKO_OFS_SYNTH_OVR, 8'hB1);
      run(8);
      `CHK(nf + ns, 0)
      $display("done synth");
   endtask
   // A frozen clock enable must hold the trigger output and pre-emphasis; a mid-run reset must clear lanes, trigger, enable, synth enable and override.
   task automatic t_freeze_reset;
      logic hold;
      hold = trigger_output;
      ce = 1'b0;
      timestamp_input = ~timestamp_input;
      wr(`CKO_OFS_PREEMPH, 8'h05);
      `CHK(trigger_output, hold)
      `CHK(lane_preemphasis_level, {8{4'hA}})
      ce = 1'b1;
      arst_n = 1'b0;
      @(negedge clk);
      `CHK({lane_preemphasis_level, trigger_output, trigger_output_enable, synth_enable}, 35'h0)
      arst_n = 1'b1;
      host.xfer(1'b0, `CKO_OFS_SYNTH_OVR, 8'h00, q);
      `CHK(q, 8'h00)
      $display("done freeze and reset");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      t_regs;
      t_trig;
      t_reinit_stamp;
      t_synth;
      t_freeze_reset;
      conclude;
   end
endmodule // tb

bind cko_top cko_chk i_cko_chk (.clk, .arst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .lane_preemphasis_level,
   .ser_reinit, .timestamp_input, .trigger_output, .trigger_output_enable, .synth_enable_pin, .ref_select_pin,
   .synth_enable, .single_ended_ref_select, .first_divided_ref_out, .second_divided_ref_out);
`default_nettype wire
